// *** design/sscr_regs.sv ***
// Second-stage configuration register bank with an AXI4-Lite slave port.
// Assumes one 50 MHz clock, synchronous active-low reset, and that the
// switching-cycle strobe, channel flag and timing inputs are same-clock
// except zcd_raw, which is a pin and is synchronised here.
// Operation
// - Period code picks 51.15 to 204.75 us limit.
// - Bit 4 picks channel for color string.
// - Minimum peak from peak and clamp codes.
// - Clamp code is two-bit offset, 0 to 3.
// - Six-bit channel-1 compensation gain.
// - Compensated time subtracts edge time times gain.
// - Sync bit gates the channel sync pin.
// - Polarity bit sets zero-detect comparator sense.
// - Minimum dim from eight-bit dim code.
// - Target period limit from eight-bit code.
`timescale 1ns/1ps
`default_nettype none
module sscr_regs (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cycle_strobe,
  input  wire logic        cycle_is_ch2,
  input  wire logic        zcd_raw,
  input  wire logic [15:0] t2_measured,
  input  wire logic [15:0] zcd_rise_time,
  output sscr_pkg::sscr_cfg_t cfg,
  output logic             chan_sync_out,
  output logic             zcd_active,
  output logic [15:0]      t2_compensated,
  output logic [17:0]      meas_period_cyc,
  output logic [8:0]       min_peak_num,
  output logic [11:0]      min_dim_num,
  output logic [21:0]      tgt_period_cyc
);
  // Raw register storage, indexed from the topology register.
  logic [7:0]  regs_r [0:4];
  logic [7:0]  regs_nxt [0:4];
  logic        ctrl_r;            // Compensation enable.
  logic        ctrl_nxt;
  // Write channel state.
  logic        aw_got_r, aw_got_nxt;
  logic        w_got_r, w_got_nxt;
  logic [31:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic        w_strb0_r, w_strb0_nxt;
  logic        bvalid_nxt;
  logic [1:0]  bresp_nxt;
  logic        awready_nxt, wready_nxt;
  // Read channel state.
  logic        arready_nxt, rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_nxt;
  // Datapath and pin state.
  logic        zcd_s1_r, zcd_s2_r;  // Pin synchroniser.
  logic        sync_nxt, zact_nxt;
  logic [15:0] t2c_nxt;
  logic [21:0] comp_prod;           // Edge time times gain, gain in 1/16 units.
  sscr_pkg::sscr_cfg_t cfg_nxt;

  // Maps a byte address to a register slot; 3'h7 marks an unmapped address.
  function automatic logic [2:0] slot_of(input logic [31:0] addr);
    logic [29:0] idx;
    idx = addr[31:2];
    if (addr[1:0] != 2'b00)                              slot_of = 3'h7;
    else if (idx == {22'h000000, sscr_pkg::IDX_TOPOLOGY})   slot_of = 3'h0;
    else if (idx == {22'h000000, sscr_pkg::IDX_GAIN_SYNC})  slot_of = 3'h1;
    else if (idx == {22'h000000, sscr_pkg::IDX_MIN_DIM})    slot_of = 3'h2;
    else if (idx == {22'h000000, sscr_pkg::IDX_TGT_PERIOD}) slot_of = 3'h3;
    else if (idx == {22'h000000, sscr_pkg::IDX_CLAMP})      slot_of = 3'h4;
    else if (idx == {22'h000000, sscr_pkg::IDX_CTRL})       slot_of = 3'h5;
    else if (idx == {22'h000000, sscr_pkg::IDX_STATUS})     slot_of = 3'h6;
    else                                                   slot_of = 3'h7;
  endfunction

  // Write path: accepts address and data in either order, then answers.
  always_comb
  begin
    logic [2:0] ws;
    ws          = 3'h7;
    aw_got_nxt  = aw_got_r;
    w_got_nxt   = w_got_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_strb0_nxt = w_strb0_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    ctrl_nxt    = ctrl_r;
    // By default every register keeps its value.
    for (int i = 0; i < 5; i++)
      regs_nxt[i] = regs_r[i];
    // Address taken: hold it until the data half has arrived too.
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_nxt  = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    // Data taken: only byte lane 0 is stored, so only its strobe is kept.
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_nxt   = 1'b1;
      w_data_nxt  = s_axi_wdata;
      w_strb0_nxt = s_axi_wstrb[0];
    end
    // Response accepted by the master.
    if (s_axi_bvalid && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (aw_got_r && w_got_r && !s_axi_bvalid)
    begin
      // Both halves held: commit and raise the response.
      ws         = slot_of(aw_addr_r);
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = (ws == 3'h7 || ws == 3'h6) ? sscr_pkg::RESP_SLVERR : sscr_pkg::RESP_OKAY;
      // A cleared lane-0 strobe leaves storage alone but still answers OKAY at a writable slot.
      if (w_strb0_r && ws < 3'h5)
        regs_nxt[ws] = w_data_r[7:0];
      else if (w_strb0_r && ws == 3'h5)
        ctrl_nxt = w_data_r[sscr_pkg::COMP_EN_BIT];
    end
    // Each ready stays low from its handshake until the response is raised.
    awready_nxt = !aw_got_nxt && !(s_axi_awvalid && s_axi_awready);
    wready_nxt  = !w_got_nxt && !(s_axi_wvalid && s_axi_wready);
  end

  // Read path: one read at a time, answer one cycle after the address.
  always_comb
  begin
    logic [2:0] rs;
    rs          = slot_of(s_axi_araddr);
    // After reset, and whenever no answer is pending, the port offers to take an address.
    arready_nxt = s_axi_arready || !s_axi_rvalid;
    rvalid_nxt  = s_axi_rvalid;
    rdata_nxt   = s_axi_rdata;
    rresp_nxt   = s_axi_rresp;
    // Read data accepted: the port may take the next address.
    if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    // Address taken: the answer stands from the next edge.
    if (s_axi_arvalid && s_axi_arready)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = sscr_pkg::RESP_OKAY;
      unique case (rs)
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4: rdata_nxt = {24'h000000, regs_r[rs]};
        3'h5: rdata_nxt = {31'h00000000, ctrl_r};
        // Status word: zero-detect, sync pin, dim numerator, peak numerator.
        3'h6: rdata_nxt = {2'b00, zcd_active, chan_sync_out, min_dim_num, 7'h00, min_peak_num[8:0]};
        default:
        begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = sscr_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Registers both bus channels and the storage.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      regs_r[0]     <= sscr_pkg::RST_TOPOLOGY;
      regs_r[1]     <= sscr_pkg::RST_GAIN_SYNC;
      regs_r[2]     <= sscr_pkg::RST_MIN_DIM;
      regs_r[3]     <= sscr_pkg::RST_TGT_PERIOD;
      regs_r[4]     <= sscr_pkg::RST_CLAMP;
      ctrl_r        <= sscr_pkg::RST_CTRL[0];
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 32'h00000000;
      w_data_r      <= 32'h00000000;
      w_strb0_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < 5; i++)
        regs_r[i] <= regs_nxt[i];
      ctrl_r        <= ctrl_nxt;
      aw_got_r      <= aw_got_nxt;
      w_got_r       <= w_got_nxt;
      aw_addr_r     <= aw_addr_nxt;
      w_data_r      <= w_data_nxt;
      w_strb0_r     <= w_strb0_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready  <= wready_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rdata   <= rdata_nxt;
      s_axi_rresp   <= rresp_nxt;
    end
  end

  // Decodes fields into the configuration carrier; bit 0 of topology is ignored.
  always_comb
  begin
    cfg_nxt.series_strings         = regs_r[0][sscr_pkg::STRING_BIT];
    cfg_nxt.meas_period_limit_code = regs_r[0][sscr_pkg::MPL_HI:sscr_pkg::MPL_LO];
    cfg_nxt.color_channel_sel      = regs_r[0][sscr_pkg::COLOR_BIT];
    cfg_nxt.min_peak_code          = regs_r[0][sscr_pkg::PEAK_HI:sscr_pkg::PEAK_LO];
    cfg_nxt.clamp_code             = regs_r[4][sscr_pkg::CLAMP_HI:sscr_pkg::CLAMP_LO];
    cfg_nxt.ch1_comp_gain          = regs_r[1][sscr_pkg::GAIN_HI:sscr_pkg::GAIN_LO];
    cfg_nxt.sync_enable            = regs_r[1][sscr_pkg::SYNC_BIT];
    cfg_nxt.zero_detect_polarity   = regs_r[1][sscr_pkg::POL_BIT];
    cfg_nxt.min_dim_code           = regs_r[2];
    cfg_nxt.target_period_limit    = regs_r[3];
    cfg_nxt.t_comp_enable          = ctrl_r;
  end

  // Computes pin outputs and the compensated T2 time.
  always_comb
  begin
    // Gain code over 16 spans 0.0 to just under 4.0.
    comp_prod = 22'(zcd_rise_time * {10'h000, cfg.ch1_comp_gain});
    // Without compensation the measured time passes straight through.
    if (!cfg.t_comp_enable)
      t2c_nxt = t2_measured;
    else if ({6'h00, t2_measured} > (comp_prod >> 4))
      t2c_nxt = 16'(t2_measured - 16'(comp_prod >> 4));
    else
      t2c_nxt = 16'h0000;
    // The sync pin holds its level between switching-period strobes.
    sync_nxt = chan_sync_out;
    if (!cfg.sync_enable)
      sync_nxt = 1'b0;
    else if (cycle_strobe)
      sync_nxt = cycle_is_ch2;
    // Polarity 0 means the comparator output is active low.
    zact_nxt = cfg.zero_detect_polarity ? zcd_s2_r : !zcd_s2_r;
  end

  // Registers the decoded configuration and the pin-side outputs.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cfg            <= '0;
      zcd_s1_r       <= 1'b0;
      zcd_s2_r       <= 1'b0;
      chan_sync_out  <= 1'b0;
      zcd_active     <= 1'b0;
      t2_compensated <= 16'h0000;
    end
    else if (clk_en)
    begin
      cfg            <= cfg_nxt;
      // The first synchroniser stage feeds only the second.
      zcd_s1_r       <= zcd_raw;
      zcd_s2_r       <= zcd_s1_r;
      chan_sync_out  <= sync_nxt;
      zcd_active     <= zact_nxt;
      t2_compensated <= t2c_nxt;
    end
  end

  // Turns the configuration into controller limits.
  sscr_derive u_derive (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .cfg             (cfg),
    .meas_period_cyc (meas_period_cyc),
    .min_peak_num    (min_peak_num),
    .min_dim_num     (min_dim_num),
    .tgt_period_cyc  (tgt_period_cyc)
  );
endmodule // sscr_regs
`default_nettype wire

// *** design/sscr_pkg.sv ***
// Package for the second-stage configuration register bank.
// Assumes a single 50 MHz clock and an AXI4-Lite register port with 32-bit data.
`default_nettype none
package sscr_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_TOPOLOGY   = 8'h23;
  localparam logic [7:0] IDX_GAIN_SYNC  = 8'h24;
  localparam logic [7:0] IDX_MIN_DIM    = 8'h25;
  localparam logic [7:0] IDX_TGT_PERIOD = 8'h26;
  localparam logic [7:0] IDX_CLAMP      = 8'h27;  // Clamp offset register of this bank.
  localparam logic [7:0] IDX_STATUS     = 8'h28;  // Derived-limit readback.
  localparam logic [7:0] IDX_STATUS2    = 8'h29;  // Not decoded; reads and writes answer SLVERR.
  localparam logic [7:0] IDX_CTRL       = 8'h2a;  // Compensation enable.
  // Reset values.
  localparam logic [7:0] RST_TOPOLOGY   = 8'h00;
  localparam logic [7:0] RST_GAIN_SYNC  = 8'h00;
  localparam logic [7:0] RST_MIN_DIM    = 8'h00;
  localparam logic [7:0] RST_TGT_PERIOD = 8'h00;
  localparam logic [7:0] RST_CLAMP      = 8'h00;
  localparam logic [7:0] RST_CTRL       = 8'h00;
  // Field positions.
  localparam int STRING_BIT   = 7;
  localparam int MPL_HI       = 6;
  localparam int MPL_LO       = 5;
  localparam int COLOR_BIT    = 4;
  localparam int PEAK_HI      = 3;
  localparam int PEAK_LO      = 1;
  localparam int GAIN_HI      = 7;
  localparam int GAIN_LO      = 2;
  localparam int SYNC_BIT     = 1;
  localparam int POL_BIT      = 0;
  localparam int CLAMP_HI     = 7;
  localparam int CLAMP_LO     = 6;
  localparam int COMP_EN_BIT  = 0;
  // Measurable-period limits in ns, indexed by code.
  localparam int MPL_NS_0 = 51150;
  localparam int MPL_NS_1 = 102350;
  localparam int MPL_NS_2 = 153550;
  localparam int MPL_NS_3 = 204750;
  localparam int CLK_NS   = 20;
  // Derived formula constants.
  localparam int PEAK_STEP  = 16;
  localparam int PEAK_ADD   = 15;
  localparam int CLAMP_STEP = 8;
  localparam int CLAMP_ADD  = 8;
  localparam int DIM_STEP   = 16;
  localparam int DIM_ADD    = 15;
  localparam int TT_STEP    = 128;
  localparam int TT_ADD     = 127;
  localparam int TT_UNIT_NS = 50;
  localparam int TT_UNIT_CYC = (TT_UNIT_NS + CLK_NS - 1) / CLK_NS;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Decoded configuration handed to the converter logic.
  typedef struct packed {
    logic        series_strings;
    logic [1:0]  meas_period_limit_code;
    logic        color_channel_sel;
    logic [2:0]  min_peak_code;
    logic [1:0]  clamp_code;
    logic [5:0]  ch1_comp_gain;
    logic        sync_enable;
    logic        zero_detect_polarity;
    logic [7:0]  min_dim_code;
    logic [7:0]  target_period_limit;
    logic        t_comp_enable;
  } sscr_cfg_t;
endpackage
`default_nettype wire

// *** design/sscr_derive.sv ***
// Turns the raw configuration into the limits the second-stage controller uses.
// Assumes cfg is a register output on the same clock; results are registered.
`timescale 1ns/1ps
`default_nettype none
module sscr_derive (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire sscr_pkg::sscr_cfg_t cfg,
  output logic [17:0]              meas_period_cyc,
  output logic [8:0]               min_peak_num,
  output logic [11:0]              min_dim_num,
  output logic [21:0]              tgt_period_cyc
);
  logic [17:0] mpc_nxt;   // Period limit in clock cycles.
  logic [8:0]  mpn_nxt;   // Peak numerator over 512 (times 1.4 V).
  logic [11:0] mdn_nxt;   // Dim numerator over 4095.
  logic [21:0] tpc_nxt;   // Target period in clock cycles.
  logic [9:0]  peak_sum;  // Peak term before the clamp offset.
  logic [9:0]  clamp_sum; // Clamp offset term.

  // Computes each limit combinationally from the fields.
  always_comb
  begin
    unique case (cfg.meas_period_limit_code)
      2'b00: mpc_nxt = 18'(sscr_pkg::MPL_NS_0 / sscr_pkg::CLK_NS);
      2'b01: mpc_nxt = 18'(sscr_pkg::MPL_NS_1 / sscr_pkg::CLK_NS);
      2'b10: mpc_nxt = 18'(sscr_pkg::MPL_NS_2 / sscr_pkg::CLK_NS);
      2'b11: mpc_nxt = 18'(sscr_pkg::MPL_NS_3 / sscr_pkg::CLK_NS);
    endcase
    peak_sum  = 10'((({7'h00, cfg.min_peak_code} + 10'h001) * 10'(sscr_pkg::PEAK_STEP))
                + 10'(sscr_pkg::PEAK_ADD));
    clamp_sum = 10'(({8'h00, cfg.clamp_code} * 10'(sscr_pkg::CLAMP_STEP))
                + 10'(sscr_pkg::CLAMP_ADD));
    mpn_nxt   = 9'(peak_sum - clamp_sum);
    mdn_nxt   = 12'(({4'h0, cfg.min_dim_code} * 12'(sscr_pkg::DIM_STEP))
                + 12'(sscr_pkg::DIM_ADD));
    tpc_nxt   = 22'((({14'h0000, cfg.target_period_limit} * 22'(sscr_pkg::TT_STEP))
                + 22'(sscr_pkg::TT_ADD)) * 22'(sscr_pkg::TT_UNIT_NS) / 22'(sscr_pkg::CLK_NS));
  end

  // Registers the limits; clock enable freezes them.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      meas_period_cyc <= 18'h00000;
      min_peak_num    <= 9'h000;
      min_dim_num     <= 12'h000;
      tgt_period_cyc  <= 22'h000000;
    end
    else if (clk_en)
    begin
      meas_period_cyc <= mpc_nxt;
      min_peak_num    <= mpn_nxt;
      min_dim_num     <= mdn_nxt;
      tgt_period_cyc  <= tpc_nxt;
    end
  end
endmodule // sscr_derive
`default_nettype wire

// *** test/sscr_regs_checker.sv ***
// Concurrent checks on the ports of the second-stage configuration register bank.
// Assumes it is bound to sscr_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sscr_regs_checker (
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic                clk_en,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                cycle_strobe,
  input wire logic                cycle_is_ch2,
  input wire logic                zcd_raw,
  input wire logic [15:0]         t2_measured,
  input wire logic [15:0]         zcd_rise_time,
  input wire sscr_pkg::sscr_cfg_t cfg,
  input wire logic                chan_sync_out,
  input wire logic                zcd_active,
  input wire logic [15:0]         t2_compensated,
  input wire logic [17:0]         meas_period_cyc,
  input wire logic [8:0]          min_peak_num,
  input wire logic [11:0]         min_dim_num,
  input wire logic [21:0]         tgt_period_cyc
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Period limit in whole clock cycles for each code.
  function automatic logic [17:0] mpl_cyc(input logic [1:0] c);
    case (c)
      2'h0: return 18'h009fd;
      2'h1: return 18'h013fd;
      2'h2: return 18'h01dfd;
      default: return 18'h027fd;
    endcase
  endfunction
  // Compensated time, clamped at zero so it never wraps.
  function automatic logic [15:0] comp_exp(input logic [15:0] t, input logic [15:0] z, input logic [5:0] g);
    logic [21:0] p;
    p = (22'(z) * 22'(g)) >> 4;
    return (22'(t) > p) ? t - p[15:0] : 16'h0000;
  endfunction
  AST_MEAS_PERIOD: assert property ((clk_en && $stable(cfg)) [*4]
    |-> meas_period_cyc == mpl_cyc(cfg.meas_period_limit_code)) else $error("period limit wrong");
  AST_MIN_PEAK: assert property ((clk_en && $stable(cfg)) [*4]
    |-> min_peak_num == (cfg.min_peak_code + 9'h1) * 9'h10 + 9'hf - cfg.clamp_code * 9'h8 - 9'h8)
    else $error("minimum peak wrong");
  AST_MIN_DIM: assert property ((clk_en && $stable(cfg)) [*4]
    |-> min_dim_num == cfg.min_dim_code * 12'h10 + 12'hf) else $error("minimum dim wrong");
  AST_TGT_PERIOD: assert property ((clk_en && $stable(cfg)) [*4]
    |-> tgt_period_cyc == 22'((32'(cfg.target_period_limit) * 32'h80 + 32'h7f) * 32'h32 / 32'h14))
    else $error("target period limit wrong");
  AST_SYNC_OFF: assert property ((clk_en && !cfg.sync_enable) [*2] |-> !chan_sync_out)
    else $error("sync pin not gated");
  AST_SYNC_ON: assert property (clk_en && cycle_strobe && cfg.sync_enable ##1 cfg.sync_enable
    |-> chan_sync_out == $past(cycle_is_ch2)) else $error("sync pin not following channel");
  AST_ZCD_POL: assert property ((clk_en && $stable(cfg.zero_detect_polarity)) [*4]
    |-> zcd_active == ($past(zcd_raw, 3) ^ !cfg.zero_detect_polarity)) else $error("zero detect sense wrong");
  AST_T2_COMP: assert property ((clk_en && $stable(cfg) && $stable(t2_measured) && $stable(zcd_rise_time))
    [*3] |-> t2_compensated == (cfg.t_comp_enable ? comp_exp(t2_measured, zcd_rise_time, cfg.ch1_comp_gain)
    : t2_measured)) else $error("compensated time wrong");
  AST_WRITE_RESP: assert property (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  AST_READ_RESP: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule // sscr_regs_checker
bind sscr_regs sscr_regs_checker chk (.*);
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the second-stage configuration register bank.
// Assumes the checker is bound to the design; registers are reached over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic [31:0]         s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]          s_axi_wstrb = 4'hf;
  logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic                s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic                cycle_strobe = 1'b0, cycle_is_ch2 = 1'b0, zcd_raw = 1'b0;
  logic [15:0]         t2_measured = 16'h0, zcd_rise_time = 16'h0, t2_compensated;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic                chan_sync_out, zcd_active;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  sscr_pkg::sscr_cfg_t cfg;
  logic [17:0]         meas_period_cyc;
  logic [8:0]          min_peak_num;
  logic [11:0]         min_dim_num;
  logic [21:0]         tgt_period_cyc;
  int                  num_errors = 0, tests_run = 0;
  int                  mpl_ns [4] = '{32'h0000c7ce, 32'h00018fce, 32'h000257ce, 32'h00031fce};
  sscr_regs dut (.*);
  // The clock runs at 50 MHz.
  always #10 ref_clk = ~ref_clk;
  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One AXI4-Lite write; address and data are offered together.
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
    bit done = 1'b0;
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done)
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        done = 1'b1;
      end
    end
  endtask
  // One AXI4-Lite read; rready stays high throughout.
  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    bit done = 1'b0;
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    while (!done)
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        done = 1'b1;
      end
    end
  endtask
  // Full-word write that must be accepted.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(idx, 32'(d), 4'hf, r);
    check(32'(r), 32'(sscr_pkg::RESP_OKAY));
  endtask
  // Read that must be accepted and return the given word.
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(idx, d, r);
    check(32'(r), 32'(sscr_pkg::RESP_OKAY));
    check(d, exp);
  endtask
  // Marks one switching period for the given channel.
  task automatic strobe(input logic ch2);
    repeat (2) @(posedge ref_clk);
    cycle_is_ch2 <= ch2;
    cycle_strobe <= 1'b1;
    @(posedge ref_clk);
    cycle_strobe <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // Every writable register starts at zero.
  task automatic t_reset;
    logic [7:0] regs [6] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2a};
    foreach (regs[i]) rd_chk(regs[i], 32'h0);
    $display("reset test done");
  endtask
  // Topology fields, period limit codes, peak and clamp codes.
  task automatic t_topology;
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = {i[2], i[1:0], i[0], i[2:0], i[0]};
      wr(8'h27, {i[1:0], 6'h00});
      wr(8'h23, v);
      rd_chk(8'h23, 32'(v));
      repeat (4) @(posedge ref_clk);
      check(32'(cfg.series_strings), 32'(i[2]));
      check(32'(cfg.color_channel_sel), 32'(i[0]));
      check(32'(meas_period_cyc), mpl_ns[i % 4] / 32'h14);
      check(32'(min_peak_num), (i + 1) * 32'h10 + 32'hf - ((i % 4) * 32'h8 + 32'h8));
    end
    $display("topology test done");
  endtask
  // Gain field, sync pin gating and zero-detect polarity.
  task automatic t_sync;
    wr(8'h24, 8'hfc);
    rd_chk(8'h24, 32'h000000fc);
    check(32'(cfg.ch1_comp_gain), 32'h3f);
    strobe(1'b1);
    check(32'(chan_sync_out), 32'h0);
    zcd_raw <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check(32'(zcd_active), 32'h0);
    wr(8'h24, 8'h57);
    strobe(1'b1);
    check(32'(chan_sync_out), 32'h1);
    strobe(1'b0);
    check(32'(chan_sync_out), 32'h0);
    check(32'(zcd_active), 32'h1);
    $display("sync test done");
  endtask
  // Compensated time with several gains, including underflow, then bypass.
  task automatic t_comp;
    logic [5:0]  g [3] = '{6'h20, 6'h3f, 6'h00};
    logic [15:0] z [3] = '{16'h0064, 16'h0400, 16'h0010};
    logic [15:0] p;
    wr(8'h2a, 8'h01);
    t2_measured <= 16'h03e8;
    for (int i = 0; i < 3; i++)
    begin
      zcd_rise_time <= z[i];
      wr(8'h24, {g[i], 2'h1});
      repeat (4) @(posedge ref_clk);
      p = 16'((32'(z[i]) * 32'(g[i])) >> 4);
      check(32'(t2_compensated), (p < 16'h03e8) ? 32'(16'h03e8 - p) : 32'h0);
    end
    wr(8'h2a, 8'h00);
    repeat (4) @(posedge ref_clk);
    check(32'(t2_compensated), 32'h03e8);
    $display("compensation test done");
  endtask
  // Minimum dim and target period limits at both ends of the code range.
  task automatic t_limits;
    logic [7:0] c [3] = '{8'h00, 8'h80, 8'hff};
    foreach (c[i])
    begin
      wr(8'h25, c[i]);
      wr(8'h26, c[i]);
      rd_chk(8'h26, 32'(c[i]));
      repeat (4) @(posedge ref_clk);
      check(32'(min_dim_num), 32'(c[i]) * 32'h10 + 32'hf);
      check(32'(tgt_period_cyc), (32'(c[i]) * 32'h80 + 32'h7f) * 32'h32 / 32'h14);
    end
    $display("limits test done");
  endtask
  // Refused places, byte strobes, lane masking and the status word.
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h28, 32'h0, 4'hf, r);
    check(32'(r), 32'(sscr_pkg::RESP_SLVERR));
    axi_wr(8'h29, 32'h0, 4'hf, r);
    check(32'(r), 32'(sscr_pkg::RESP_SLVERR));
    axi_rd(8'h29, d, r);
    check(32'(r), 32'(sscr_pkg::RESP_SLVERR));
    check(d, 32'h0);
    axi_wr(8'h25, 32'habcdef12, 4'hf, r);
    axi_wr(8'h25, 32'h00000055, 4'h0, r);
    check(32'(r), 32'(sscr_pkg::RESP_OKAY));
    rd_chk(8'h25, 32'h00000012);
    repeat (4) @(posedge ref_clk);
    rd_chk(8'h28, 32'h212f006f);
    $display("bus test done");
  endtask
  // Clock enable low freezes the zero-detect output; it follows the pin again once raised.
  task automatic t_hold;
    clk_en <= 1'b0;
    zcd_raw <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check(32'(zcd_active), 32'h1);
    clk_en <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check(32'(zcd_active), 32'h0);
    $display("hold test done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after a reset of 20 cycles.
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_topology;
    t_sync;
    t_comp;
    t_limits;
    t_bus;
    t_hold;
    report_and_stop;
  end
  // Cuts a hang short well beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
